//--- design/flpw_pkg.sv
/*
 * flpw_pkg: constants, encodings and carrier structs for the four-level page walker.
 * Assumes a single core clock domain; included by import in every design file.
 */
package flpw_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int LADDR_W = 48;
   localparam int PADDR_W = 52;
   localparam int ENTRY_W = 64;
   localparam int BASE_W  = PADDR_W - 12;
   localparam int IDX_W   = 9;
   localparam int TAG_W   = 12;

   // ****************************************************************
   // field positions in the root and in table entries
   // ****************************************************************
   localparam int BIT_PRESENT  = 0;
   localparam int BIT_RW       = 1;
   localparam int BIT_US       = 2;
   localparam int BIT_PWT      = 3;
   localparam int BIT_PCD      = 4;
   localparam int BIT_ACCESSED = 5;
   localparam int BIT_PS       = 7;
   localparam int BIT_NX       = 63;
   localparam int BASE_LO      = 12;
   localparam int IDX_L4_LO    = 39;
   localparam int IDX_L3_LO    = 30;
   localparam int IDX_L2_LO    = 21;
   localparam int IDX_L1_LO    = 12;
   localparam int RSVD_LO      = 13;
   localparam int RSVD_GB_HI   = 29;
   localparam int RSVD_MB_HI   = 20;

   // ****************************************************************
   // reset values and fixed codes
   // ****************************************************************
   localparam logic [ENTRY_W-1:0] ROOT_RESET = 64'h0;
   localparam logic [TAG_W-1:0]   TAG_NONE   = 12'h000;
   localparam logic [1:0]         USER_PRIV  = 2'h3;
   localparam logic [2:0]         ENTRY_LOW0 = 3'h0;

   // ****************************************************************
   // enumerations
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01
   } flpw_state_e;

   typedef enum logic [1:0] {
      LVL_1 = 2'b00,
      LVL_2 = 2'b01,
      LVL_3 = 2'b10,
      LVL_4 = 2'b11
   } flpw_level_e;

   typedef enum logic [1:0] {
      SZ_4K = 2'b00,
      SZ_2M = 2'b01,
      SZ_1G = 2'b10
   } flpw_size_e;

   typedef enum logic [2:0] {
      CS_NONE        = 3'b000,
      CS_MODE_OFF    = 3'b001,
      CS_NOT_PRESENT = 3'b010,
      CS_RESERVED    = 3'b011,
      CS_WRITE       = 3'b100,
      CS_USER        = 3'b101,
      CS_NO_EXEC     = 3'b110
   } flpw_cause_e;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [LADDR_W-1:0] laddr;
      logic               write;
      logic               fetch;
      logic [1:0]         priv;
   } flpw_req_s;

   typedef struct packed {
      logic [PADDR_W-1:0] paddr;
      logic               fault;
      flpw_cause_e        cause;
      flpw_size_e         size;
   } flpw_rsp_s;

   typedef struct packed {
      logic [PADDR_W-1:0] addr;
      logic               walk_write_through;
      logic               walk_cache_disable;
   } flpw_mem_s;

endpackage : flpw_pkg

//--- design/flpw_walker.sv
/*
 * flpw_walker: four-level linear-to-physical translation walker with its root register.
 * Assumes the core, control bits and memory port all run on REF_CLK; memory answers
 * one entry read per MEM_REQ with MEM_ACK and MEM_RDATA in the same cycle.
 */
// Overview of operation
// RQ1: walk only when paging, extension, long mode on
// RQ2: 48-bit linear in, 52-bit physical out
// RQ3: tags off: root bits 4:3 give fetch attributes
// RQ4: tags on: root bits 11:0 are the tag
// RQ5: root bits M-1:12 hold top table base
// RQ6: enable change takes effect at once, tag zero
// RQ7: after disabling tags, bits 4:3 are attributes
// RQ8: physical bits above max width forced zero
// RQ9: walk ends on 4K, 2M or 1G page
// RQ10: top entry address from root and bits 47:39
// RQ11: third-level address from entry and bits 38:30
// RQ12: third-level size flag set ends on 1G
// RQ13: else second-level address uses bits 29:21
// RQ14: size flag reserved without 1G page support
// RQ15: top entry present bit; bit 7 reserved
// RQ16: top read/write bit clear may refuse writes
// RQ17: top user bit clear refuses level-3 accesses
// RQ18: top entry bits 4:3 attribute next fetch
// RQ19: top entry accessed bit records use
// RQ20: no-execute bit forbids fetches when enabled
// RQ21: entry base bits, reserved and ignored bits
// RQ22: reserved bit set raises page fault
// RQ23: second-level size flag set ends on 2M
// RQ24: absent entry stops walk with page fault
// RQ25: second-level flag clear walks to 4K page
module flpw_walker
   import flpw_pkg::*;
#(
   parameter int MAX_PHYS_WIDTH     = 52,
   parameter bit GB_PAGES_SUPPORTED = 1'b1
) (
   input  logic                REF_CLK,
   input  logic                ARST_N,
   input  logic                PAGING_ON,
   input  logic                EXT_PHYS_ON,
   input  logic                LONG_MODE_ON,
   input  logic                NO_EXEC_FEATURE_ON,
   input  logic                CONTEXT_TAG_ENABLE,
   input  logic                SUP_WRITE_PROTECT,
   input  logic                ROOT_WR,
   input  logic [ENTRY_W-1:0]  ROOT_WDATA,
   output logic [ENTRY_W-1:0]  ROOT_RDATA,
   output logic [TAG_W-1:0]    CONTEXT_TAG,
   output logic                MODE_ACTIVE,
   input  logic                REQ_VALID,
   output logic                REQ_READY,
   input  flpw_req_s           REQ,
   output logic                RSP_VALID,
   output flpw_rsp_s           RSP,
   output logic                MEM_REQ,
   output flpw_mem_s           MEM,
   input  logic                MEM_ACK,
   input  logic [ENTRY_W-1:0]  MEM_RDATA,
   output logic                ACC_MARK_VALID,
   output logic [PADDR_W-1:0]  ACC_MARK_ADDR
);

   // ****************************************************************
   // state
   // ****************************************************************
   flpw_state_e        state_reg;
   flpw_state_e        state_next;
   flpw_level_e        level_reg;
   flpw_level_e        level_next;
   flpw_req_s          req_reg;
   flpw_req_s          req_next;
   flpw_mem_s          mem_reg;
   flpw_mem_s          mem_next;
   flpw_rsp_s          rsp_reg;
   flpw_rsp_s          rsp_next;
   logic               rsp_valid_reg;
   logic               rsp_valid_next;
   logic               rw_reg;
   logic               rw_next;
   logic               us_reg;
   logic               us_next;
   logic               nx_reg;
   logic               nx_next;
   logic               mark_valid_reg;
   logic               mark_valid_next;
   logic [PADDR_W-1:0] mark_addr_reg;
   logic [PADDR_W-1:0] mark_addr_next;
   logic [ENTRY_W-1:0] translation_root_reg;
   logic [ENTRY_W-1:0] translation_root_next;

   // ****************************************************************
   // root interpretation
   // ****************************************************************
   // RQ8: mask of implemented physical bits
   localparam logic [PADDR_W-1:0] PA_MASK = (52'h1 << MAX_PHYS_WIDTH) - 52'h1;

   wire                 mode_on;
   wire [BASE_W-1:0]    root_base;
   wire                 root_pwt;
   wire                 root_pcd;
   wire [PADDR_W-1:0]   top_addr;

   // RQ1: all three enables required
   assign mode_on     = PAGING_ON & EXT_PHYS_ON & LONG_MODE_ON;
   assign MODE_ACTIVE = mode_on;
   assign ROOT_RDATA  = translation_root_reg;

   // RQ5: base from M-1:12, upper bits masked
   assign root_base = translation_root_reg[PADDR_W-1:BASE_LO] & PA_MASK[PADDR_W-1:BASE_LO];

   // RQ6: decoded live from the enable, so a change acts at once
   // RQ4: tag is the low twelve bits when enabled
   assign CONTEXT_TAG = CONTEXT_TAG_ENABLE ? translation_root_reg[TAG_W-1:0] : TAG_NONE;

   // RQ3: attributes only when tags are off
   // RQ7: the same bits serve again after disabling
   assign root_pwt = ~CONTEXT_TAG_ENABLE & translation_root_reg[BIT_PWT];
   assign root_pcd = ~CONTEXT_TAG_ENABLE & translation_root_reg[BIT_PCD];

   // RQ10: top entry address
   assign top_addr = {root_base, REQ.laddr[IDX_L4_LO+:IDX_W], ENTRY_LOW0};

   // ****************************************************************
   // entry decode
   // ****************************************************************
   wire                 e_present;
   wire                 e_ps;
   wire [BASE_W-1:0]    e_base;
   wire                 hi_rsvd;
   wire                 nx_rsvd;
   wire                 lvl_rsvd;
   wire                 rsvd_hit;
   wire                 leaf;
   wire                 rw_acc;
   wire                 us_acc;
   wire                 nx_acc;
   wire                 user_req;
   wire [IDX_W-1:0]     idx_down;
   wire [PADDR_W-1:0]   down_addr;
   wire [PADDR_W-1:0]   leaf_paddr;
   flpw_level_e         level_down;
   flpw_size_e          leaf_size;
   flpw_cause_e         cause;

   assign e_present = MEM_RDATA[BIT_PRESENT];
   assign e_ps      = MEM_RDATA[BIT_PS];
   // RQ21: next-table base; bits 62:52, 11:8 and 6 never looked at
   assign e_base    = MEM_RDATA[PADDR_W-1:BASE_LO] & PA_MASK[PADDR_W-1:BASE_LO];

   // RQ21: bits 51:M reserved
   assign hi_rsvd = |(MEM_RDATA[PADDR_W-1:0] & ~PA_MASK);
   // RQ20: no-execute bit reserved when the feature is off
   assign nx_rsvd = MEM_RDATA[BIT_NX] & ~NO_EXEC_FEATURE_ON;

   // RQ15: top entry bit 7 reserved
   // RQ14: third-level size flag reserved without 1G support
   assign lvl_rsvd = (level_reg == LVL_4) ? e_ps :
                     (level_reg == LVL_3) ? e_ps & (~GB_PAGES_SUPPORTED |
                                                    (|MEM_RDATA[RSVD_GB_HI:RSVD_LO])) :
                     (level_reg == LVL_2) ? e_ps & (|MEM_RDATA[RSVD_MB_HI:RSVD_LO]) :
                     1'b0;

   // RQ22: any reserved bit in a present entry faults
   assign rsvd_hit = hi_rsvd | nx_rsvd | lvl_rsvd;

   // RQ9: leaf at 1G, 2M or 4K level
   // RQ12: third-level flag set
   // RQ23: second-level flag set
   // RQ25: last level always a leaf
   assign leaf = (level_reg == LVL_1) | (level_reg == LVL_2 & e_ps) | (level_reg == LVL_3 & e_ps);

   // rights narrow level by level; the top entry speaks for its whole 512G region
   assign rw_acc   = rw_reg & MEM_RDATA[BIT_RW];
   assign us_acc   = us_reg & MEM_RDATA[BIT_US];
   assign nx_acc   = nx_reg | (NO_EXEC_FEATURE_ON & MEM_RDATA[BIT_NX]);
   assign user_req = (req_reg.priv == USER_PRIV);

   assign level_down = (level_reg == LVL_4) ? LVL_3 : (level_reg == LVL_3) ? LVL_2 : LVL_1;

   // RQ11: bits 38:30 below the top
   // RQ13: bits 29:21 below the third level
   // RQ25: bits 20:12 below the second level
   assign idx_down = (level_reg == LVL_4) ? req_reg.laddr[IDX_L3_LO+:IDX_W] :
                     (level_reg == LVL_3) ? req_reg.laddr[IDX_L2_LO+:IDX_W] :
                     req_reg.laddr[IDX_L1_LO+:IDX_W];
   assign down_addr = {e_base, idx_down, ENTRY_LOW0};

   // RQ2: 48-bit linear offset merged into a 52-bit frame
   // RQ8: unimplemented bits cleared on the result
   assign leaf_paddr = ((level_reg == LVL_3) ? {MEM_RDATA[PADDR_W-1:IDX_L3_LO], req_reg.laddr[IDX_L3_LO-1:0]} :
                        (level_reg == LVL_2) ? {MEM_RDATA[PADDR_W-1:IDX_L2_LO], req_reg.laddr[IDX_L2_LO-1:0]} :
                        {MEM_RDATA[PADDR_W-1:IDX_L1_LO], req_reg.laddr[IDX_L1_LO-1:0]}) & PA_MASK;
   assign leaf_size  = (level_reg == LVL_3) ? SZ_1G : (level_reg == LVL_2) ? SZ_2M : SZ_4K;

   // RQ24: absent entry first
   // RQ17: user-level access into supervisor region
   // RQ16: write refused to user, or to supervisor under protect
   // RQ20: instruction fetch from no-execute region
   assign cause = ~e_present                                          ? CS_NOT_PRESENT :
                  rsvd_hit                                            ? CS_RESERVED :
                  ~leaf                                               ? CS_NONE :
                  (user_req & ~us_acc)                                ? CS_USER :
                  (req_reg.write & ~rw_acc & (user_req | SUP_WRITE_PROTECT)) ? CS_WRITE :
                  (req_reg.fetch & nx_acc)                            ? CS_NO_EXEC :
                  CS_NONE;

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb begin
      state_next            = state_reg;
      level_next            = level_reg;
      req_next              = req_reg;
      mem_next              = mem_reg;
      rsp_next              = rsp_reg;
      rsp_valid_next        = 1'b0;
      rw_next               = rw_reg;
      us_next               = us_reg;
      nx_next               = nx_reg;
      mark_valid_next       = 1'b0;
      mark_addr_next        = mark_addr_reg;
      translation_root_next = ROOT_WR ? ROOT_WDATA : translation_root_reg;
      case (state_reg)
         ST_IDLE: begin
            if (REQ_VALID) begin
               req_next = REQ;
               if (!mode_on) begin
                  // RQ1: no translation outside this mode
                  rsp_next       = '{paddr: '0, fault: 1'b1, cause: CS_MODE_OFF, size: SZ_4K};
                  rsp_valid_next = 1'b1;
               end else begin
                  state_next = ST_FETCH;
                  level_next = LVL_4;
                  mem_next   = '{addr: top_addr, walk_write_through: root_pwt, walk_cache_disable: root_pcd};
                  rw_next    = 1'b1;
                  us_next    = 1'b1;
                  nx_next    = 1'b0;
               end
            end
         end
         ST_FETCH: begin
            if (MEM_ACK) begin
               rw_next = rw_acc;
               us_next = us_acc;
               nx_next = nx_acc;
               // RQ19: first use of a clean top entry marks it
               if (level_reg == LVL_4 && e_present && !rsvd_hit && !MEM_RDATA[BIT_ACCESSED]) begin
                  mark_valid_next = 1'b1;
                  mark_addr_next  = mem_reg.addr;
               end
               if (cause != CS_NONE) begin
                  // RQ24: walk stops, fault answered
                  state_next     = ST_IDLE;
                  rsp_next       = '{paddr: '0, fault: 1'b1, cause: cause, size: leaf_size};
                  rsp_valid_next = 1'b1;
               end else if (leaf) begin
                  state_next     = ST_IDLE;
                  rsp_next       = '{paddr: leaf_paddr, fault: 1'b0, cause: CS_NONE, size: leaf_size};
                  rsp_valid_next = 1'b1;
               end else begin
                  // RQ15: present top entry references the next table
                  // RQ18: entry bits 4:3 attribute the next fetch
                  level_next = level_down;
                  mem_next   = '{addr: down_addr, walk_write_through: MEM_RDATA[BIT_PWT], walk_cache_disable: MEM_RDATA[BIT_PCD]};
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg            <= ST_IDLE;
         level_reg            <= LVL_4;
         req_reg              <= '0;
         mem_reg              <= '0;
         rsp_reg              <= '0;
         rsp_valid_reg        <= 1'b0;
         rw_reg               <= 1'b1;
         us_reg               <= 1'b1;
         nx_reg               <= 1'b0;
         mark_valid_reg       <= 1'b0;
         mark_addr_reg        <= '0;
         translation_root_reg <= ROOT_RESET;
      end else begin
         state_reg            <= state_next;
         level_reg            <= level_next;
         req_reg              <= req_next;
         mem_reg              <= mem_next;
         rsp_reg              <= rsp_next;
         rsp_valid_reg        <= rsp_valid_next;
         rw_reg               <= rw_next;
         us_reg               <= us_next;
         nx_reg               <= nx_next;
         mark_valid_reg       <= mark_valid_next;
         mark_addr_reg        <= mark_addr_next;
         translation_root_reg <= translation_root_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // a root write during a walk only affects the next walk; the top address is latched
   assign REQ_READY      = (state_reg == ST_IDLE);
   assign RSP_VALID      = rsp_valid_reg;
   assign RSP            = rsp_reg;
   assign MEM_REQ        = (state_reg == ST_FETCH);
   assign MEM            = mem_reg;
   assign ACC_MARK_VALID = mark_valid_reg;
   assign ACC_MARK_ADDR  = mark_addr_reg;

endmodule : flpw_walker

//--- tb/flpw_mem_model.sv
/* flpw_mem_model: memory holding the paging structures read by the walker.
   Assumes entries are loaded with put(); unloaded addresses read as not present. */
module flpw_mem_model
   import flpw_pkg::*;
(
   input  logic        clk,
   input  logic        mem_req,
   input  flpw_mem_s   mem,
   input  logic [1:0]  delay,
   output logic        mem_ack,
   output logic [63:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [63:0] store [logic [51:0]];
   int          wait_cnt = 0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 64'h0;
   task automatic put(input logic [51:0] a, input logic [63:0] d);
      store[a] = d;
   endtask : put
   // ****************
   // entry reads
   // ****************
   // entry served by address
   always @(posedge clk) begin
      #1;
      if (mem_req && !mem_ack && wait_cnt >= delay) begin
         mem_ack = 1'b1;
         mem_rdata = store.exists(mem.addr) ? store[mem.addr] : 64'h0;
         wait_cnt = 0;
      end else begin
         // data not held after the ack: toggled so stale reads show
         mem_ack = 1'b0;
         mem_rdata = ~mem_rdata;
         wait_cnt = mem_req ? wait_cnt + 1 : 0;
      end
   end
endmodule : flpw_mem_model

//--- tb/flpw_walker_assertions.sv
/* flpw_walker_assertions: port checker for flpw_walker.
   Assumes one REF_CLK domain; attached by the bind at the foot. */
module flpw_walker_assertions
   import flpw_pkg::*;
#(parameter int MAX_PHYS_WIDTH = 52) (
   input logic               REF_CLK,
   input logic               ARST_N,
   input logic               PAGING_ON,
   input logic               EXT_PHYS_ON,
   input logic               LONG_MODE_ON,
   input logic               CONTEXT_TAG_ENABLE,
   input logic               ROOT_WR,
   input logic [ENTRY_W-1:0] ROOT_WDATA,
   input logic [ENTRY_W-1:0] ROOT_RDATA,
   input logic [TAG_W-1:0]   CONTEXT_TAG,
   input logic               MODE_ACTIVE,
   input logic               REQ_VALID,
   input logic               REQ_READY,
   input flpw_req_s          REQ,
   input logic               RSP_VALID,
   input flpw_rsp_s          RSP,
   input logic               MEM_REQ,
   input flpw_mem_s          MEM,
   input logic               MEM_ACK,
   input logic [ENTRY_W-1:0] MEM_RDATA
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [63:0] PM = (64'h1 << MAX_PHYS_WIDTH) - 64'h1;
   wire take = REQ_VALID && REQ_READY;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   // ****************
   // properties
   // ****************
   AST_MODE_AND: assert property (MODE_ACTIVE == (PAGING_ON && EXT_PHYS_ON && LONG_MODE_ON))
      else $error("mode flag wrong");
   AST_MODE_OFF: assert property (take && !MODE_ACTIVE |=> RSP_VALID && RSP.fault && RSP.cause == CS_MODE_OFF)
      else $error("mode-off request not refused");
   AST_TAG: assert property (CONTEXT_TAG == (CONTEXT_TAG_ENABLE ? ROOT_RDATA[11:0] : TAG_NONE))
      else $error("context tag wrong");
   AST_ROOT_WR: assert property (ROOT_WR |=> ROOT_RDATA == $past(ROOT_WDATA))
      else $error("root write lost");
   AST_TOP_ADDR: assert property (take && MODE_ACTIVE |=> MEM_REQ &&
      MEM.addr == {$past(ROOT_RDATA[51:12]) & PM[51:12], $past(REQ.laddr[47:39]), 3'h0})
      else $error("top entry address wrong");
   AST_TOP_ATTR: assert property (take && MODE_ACTIVE |=>
      MEM.walk_write_through == ($past(ROOT_RDATA[3]) && !$past(CONTEXT_TAG_ENABLE)) &&
      MEM.walk_cache_disable == ($past(ROOT_RDATA[4]) && !$past(CONTEXT_TAG_ENABLE)))
      else $error("top fetch attributes wrong");
   AST_PHYS_MEM: assert property (MEM_REQ |-> (MEM.addr & ~PM[51:0]) == 52'h0 && MEM.addr[2:0] == 3'h0)
      else $error("entry address bits out of range");
   AST_MEM_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM))
      else $error("entry read dropped or changed");
   AST_NEXT_ATTR: assert property (MEM_REQ && MEM_ACK ##1 MEM_REQ |->
      MEM.walk_write_through == $past(MEM_RDATA[BIT_PWT]) && MEM.walk_cache_disable == $past(MEM_RDATA[BIT_PCD]))
      else $error("next-level fetch attributes wrong");
   AST_WALK_END: assert property (take && MODE_ACTIVE |-> ##[2:60] RSP_VALID)
      else $error("walk did not end");
   cover property (RSP_VALID && !RSP.fault && RSP.size == SZ_1G);
   cover property (RSP_VALID && !RSP.fault && RSP.size == SZ_2M);
   cover property (RSP_VALID && RSP.cause == CS_MODE_OFF);
endmodule : flpw_walker_assertions

bind flpw_walker flpw_walker_assertions #(.MAX_PHYS_WIDTH(MAX_PHYS_WIDTH)) u_chk (
   .REF_CLK(REF_CLK), .ARST_N(ARST_N), .PAGING_ON(PAGING_ON), .EXT_PHYS_ON(EXT_PHYS_ON),
   .LONG_MODE_ON(LONG_MODE_ON), .CONTEXT_TAG_ENABLE(CONTEXT_TAG_ENABLE), .ROOT_WR(ROOT_WR),
   .ROOT_WDATA(ROOT_WDATA), .ROOT_RDATA(ROOT_RDATA), .CONTEXT_TAG(CONTEXT_TAG),
   .MODE_ACTIVE(MODE_ACTIVE), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
   .RSP_VALID(RSP_VALID), .RSP(RSP), .MEM_REQ(MEM_REQ), .MEM(MEM), .MEM_ACK(MEM_ACK),
   .MEM_RDATA(MEM_RDATA));

//--- tb/test_four_level_page_walker.sv
/* test_four_level_page_walker: self-checking bench for flpw_walker.
   Assumes flpw_mem_model as memory and the bound checker; walker built with 46 physical bits. */
module test_four_level_page_walker
   import flpw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int          PW = 46;
   localparam logic [47:0] LA = 48'h1234_5678_9abc;
   localparam logic [51:0] A4 = {40'h1, LA[47:39], 3'h0};
   localparam logic [51:0] A3 = {40'h2, LA[38:30], 3'h0};
   localparam logic [51:0] A2 = {40'h3, LA[29:21], 3'h0};
   localparam logic [51:0] A1 = {40'h4, LA[20:12], 3'h0};
   logic ref_clk, arst_n, paging_on, ext_phys_on, long_mode_on, nx_on, tag_en, swp;
   logic root_wr, mode_active, req_valid, req_ready, rsp_valid, mem_req, mem_ack, acc_valid;
   logic [63:0] root_wdata, root_rdata, mem_rdata;
   logic [11:0] context_tag;
   logic [51:0] acc_addr;
   logic [1:0]  delay;
   flpw_req_s   req;
   flpw_rsp_s   rsp;
   flpw_mem_s   mem;
   int          failures = 0;
   int          checked = 0;
   int          acc_cnt = 0;
   int          a0;

   flpw_walker #(.MAX_PHYS_WIDTH(PW)) u_dut (
      .REF_CLK(ref_clk), .ARST_N(arst_n), .PAGING_ON(paging_on), .EXT_PHYS_ON(ext_phys_on),
      .LONG_MODE_ON(long_mode_on), .NO_EXEC_FEATURE_ON(nx_on), .CONTEXT_TAG_ENABLE(tag_en),
      .SUP_WRITE_PROTECT(swp), .ROOT_WR(root_wr), .ROOT_WDATA(root_wdata), .ROOT_RDATA(root_rdata),
      .CONTEXT_TAG(context_tag), .MODE_ACTIVE(mode_active), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ(req), .RSP_VALID(rsp_valid), .RSP(rsp), .MEM_REQ(mem_req),
      .MEM(mem), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .ACC_MARK_VALID(acc_valid),
      .ACC_MARK_ADDR(acc_addr));
   flpw_mem_model u_mem (.clk(ref_clk), .mem_req(mem_req), .mem(mem), .delay(delay),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (acc_valid === 1'b1) acc_cnt++;

   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   task automatic wroot(input logic [63:0] v);
      root_wr = 1'b1;
      root_wdata = v;
      @(posedge ref_clk);
      #1 root_wr = 1'b0;
   endtask : wroot
   task automatic xl(input logic wr, input logic fe, input logic [1:0] pv, input flpw_rsp_s ex);
      int n;
      req_valid = 1'b1;
      req = '{LA, wr, fe, pv};
      @(posedge ref_clk);
      #1 req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 80) begin
         @(posedge ref_clk);
         #1 n++;
      end
      if (n == 80) begin
         failures++;
         summarize();
      end
      // on a fault only flag and cause are compared
      if (ex.fault) chk(64'({rsp.fault, rsp.cause}), 64'({ex.fault, ex.cause}));
      else chk(64'(rsp), 64'(ex));
   endtask : xl
   task automatic fc(input logic [63:0] e4, input logic wr, input logic fe, input logic [1:0] pv,
                     input flpw_cause_e c);
      u_mem.put(A4, e4);
      xl(wr, fe, pv, '{52'h0, 1'b1, c, SZ_4K});
   endtask : fc
   function automatic flpw_rsp_s ok(input logic [51:0] p, input flpw_size_e s);
      return '{p, 1'b0, CS_NONE, s};
   endfunction : ok

   // ****************
   // sequence
   // ****************
   initial begin
      ref_clk = 1'b0;
      arst_n = 1'b0;
      {root_wr, root_wdata, req_valid, req} = '0;
      {paging_on, ext_phys_on, long_mode_on, nx_on, tag_en, swp} = 6'h38;
      delay = 2'h0;
      repeat (6) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      chk(root_rdata, 64'h0);
      chk({req_ready, mem_req, rsp_valid, context_tag}, {3'h4, 12'h0});
      wroot(64'h10ff);
      chk(root_rdata, 64'h10ff);
      tag_en = 1'b1;
      @(posedge ref_clk);
      #1 chk(context_tag, 12'h0ff);
      tag_en = 1'b0;
      @(posedge ref_clk);
      #1 chk(context_tag, 12'h000);
      // third-level entry carries both fetch attributes
      u_mem.put(A3, 64'h301f);
      u_mem.put(A2, 64'h4007);
      u_mem.put(A1, 64'h55007);
      u_mem.put(A4, 64'h2007);
      a0 = acc_cnt;
      xl(1'b0, 1'b0, 2'h0, ok({40'h55, LA[11:0]}, SZ_4K));
      chk(acc_cnt - a0, 1);
      chk(acc_addr, A4);
      tag_en = 1'b1;
      delay = 2'h3;
      u_mem.put(A4, 64'h2027);
      a0 = acc_cnt;
      xl(1'b0, 1'b0, 2'h3, ok({40'h55, LA[11:0]}, SZ_4K));
      chk(acc_cnt - a0, 0);
      tag_en = 1'b0;
      delay = 2'h1;
      u_mem.put(A2, 64'h60_0087);
      xl(1'b0, 1'b0, 2'h0, ok(52'h60_0000 | LA[20:0], SZ_2M));
      u_mem.put(A3, 64'h4000_0087);
      xl(1'b0, 1'b0, 2'h0, ok(52'h4000_0000 | LA[29:0], SZ_1G));
      // bit 50 lies above the 46-bit physical width
      u_mem.put(A3, 64'h0004_0000_4000_0087);
      fc(64'h2007, 1'b0, 1'b0, 2'h0, CS_RESERVED);
      u_mem.put(A3, 64'h3007);
      u_mem.put(A2, 64'h0);
      fc(64'h2007, 1'b0, 1'b0, 2'h0, CS_NOT_PRESENT);
      u_mem.put(A2, 64'h4007);
      fc(64'h2006, 1'b0, 1'b0, 2'h0, CS_NOT_PRESENT);
      fc(64'h2087, 1'b0, 1'b0, 2'h0, CS_RESERVED);
      fc(64'h2003, 1'b0, 1'b0, 2'h3, CS_USER);
      u_mem.put(A4, 64'h2005);
      xl(1'b1, 1'b0, 2'h0, ok({40'h55, LA[11:0]}, SZ_4K));
      swp = 1'b1;
      fc(64'h2005, 1'b1, 1'b0, 2'h0, CS_WRITE);
      swp = 1'b0;
      nx_on = 1'b1;
      fc(64'h8000_0000_0000_2007, 1'b0, 1'b1, 2'h0, CS_NO_EXEC);
      nx_on = 1'b0;
      fc(64'h8000_0000_0000_2007, 1'b0, 1'b1, 2'h0, CS_RESERVED);
      for (int i = 0; i < 3; i++) begin
         {paging_on, ext_phys_on, long_mode_on} = ~(3'h1 << i);
         fc(64'h2007, 1'b0, 1'b0, 2'h0, CS_MODE_OFF);
         chk(mode_active, 1'b0);
      end
      summarize();
   end
endmodule : test_four_level_page_walker
